// >>> core/adc_cfg_bank.sv
/*
 * Configuration register bank of a dual-channel converter, reached over a
 * three-wire serial port (clock, active-low select, bidirectional data).
 * Assumes the serial clock is asynchronous to sys_clk and that each of its
 * half periods spans at least six sys_clk cycles, so that the three-stage
 * pin synchronisers see every edge.
 */
`timescale 1ns/1ps

module adc_cfg_bank
	import adc_cfg_pkg::*;
#(
	parameter logic [7:0] CHIP_IDENTIFIER = 8'h5a,     // Arbitrary value.
	parameter logic [2:0] SPEED_GRADE = 3'h3
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire serial_pins_t pins_in,
	output logic sdio_out,
	output logic sdio_oe,
	output chan_cfg_t chan_a_cfg,
	output chan_cfg_t chan_b_cfg,
	output logic duty_cycle_stabilizer,
	output logic [2:0] clk_div_ratio,
	output logic conv_clk_en,
	output logic lsb_first
);

	typedef enum logic [1:0] {
		PH_INSTR = 2'b00,
		PH_DATA = 2'b01,
		PH_DONE = 2'b10
	} phase_t;

	// Three-stage synchronisers; a level counts once stages two and three agree.
	logic [2:0] sync1_reg, sync2_reg, sync3_reg;
	serial_pins_t pin_reg;
	logic sclk_prev_reg;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			sync1_reg <= 3'h2;
			sync2_reg <= 3'h2;
			sync3_reg <= 3'h2;
			pin_reg <= 3'h2;
			sclk_prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= pins_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			for (int i = 0; i < 3; i++)
			begin
				if (sync2_reg[i] == sync3_reg[i])
					pin_reg[i] <= sync3_reg[i];
			end
			sclk_prev_reg <= pin_reg.sclk;
		end
	end

	logic sclk_rise, sclk_fall, selected;
	assign selected = !pin_reg.csb_n;
	assign sclk_rise = pin_reg.sclk && !sclk_prev_reg && selected;
	assign sclk_fall = !pin_reg.sclk && sclk_prev_reg && selected;

	// Register state.
	logic lsb_first_reg, soft_reset_reg, commit_reg;
	logic [1:0] chan_sel_reg;
	chan_cfg_t shadow_a_reg, shadow_b_reg, active_a_reg, active_b_reg;
	logic shadow_dcs_reg, active_dcs_reg;
	logic [2:0] shadow_div_reg, active_div_reg;
	logic load_defaults;
	assign load_defaults = !rst_n || soft_reset_reg;

	// Serial frame state.
	phase_t phase_reg;
	logic [3:0] bit_cnt_reg;
	logic [15:0] instr_reg;
	logic [7:0] data_reg, rd_byte_reg;
	logic [12:0] addr_reg;
	logic read_reg, stream_reg, load_rd_reg;
	logic [1:0] bytes_left_reg;
	logic wr_en_reg;
	logic [12:0] wr_addr_reg;
	logic [7:0] wr_data_reg;

	// Bit position for the incoming serial bit under the current bit order.
	logic [3:0] instr_pos;
	logic [2:0] data_pos;
	logic [15:0] instr_full;
	logic [7:0] data_full;
	always_comb
	begin
		instr_pos = lsb_first_reg ? bit_cnt_reg : INSTR_LAST - bit_cnt_reg;
		data_pos = lsb_first_reg ? bit_cnt_reg[2:0] : 3'h7 - bit_cnt_reg[2:0];
		instr_full = instr_reg;
		instr_full[instr_pos] = pin_reg.sdio;
		data_full = data_reg;
		data_full[data_pos] = pin_reg.sdio;
	end

	// Streaming runs downward in MSB-first order and upward in LSB-first.
	logic [12:0] addr_step;
	assign addr_step = lsb_first_reg ? addr_reg + 13'h0001
		: addr_reg - 13'h0001;

	always_ff @(posedge sys_clk)
	begin
		wr_en_reg <= 1'b0;
		load_rd_reg <= 1'b0;
		if (!rst_n || !selected)
		begin
			phase_reg <= PH_INSTR;
			bit_cnt_reg <= 4'h0;
			instr_reg <= 16'h0000;
			data_reg <= 8'h00;
			addr_reg <= 13'h0000;
			read_reg <= 1'b0;
			stream_reg <= 1'b0;
			bytes_left_reg <= 2'h0;
			wr_addr_reg <= 13'h0000;
			wr_data_reg <= 8'h00;
		end
		else if (sclk_rise)
		begin
			case (phase_reg)
				PH_INSTR:
				begin
					instr_reg <= instr_full;
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == INSTR_LAST)
					begin
						bit_cnt_reg <= 4'h0;
						phase_reg <= PH_DATA;
						read_reg <= instr_full[INSTR_RW_BIT];
						addr_reg <= instr_full[ADDR_W-1:0];
						bytes_left_reg <= instr_full[INSTR_LEN_HI:INSTR_LEN_LO];
						stream_reg <= instr_full[INSTR_LEN_HI:INSTR_LEN_LO]
							== LEN_STREAM;
						load_rd_reg <= instr_full[INSTR_RW_BIT];
					end
				end
				PH_DATA:
				begin
					data_reg <= data_full;
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == BYTE_LAST)
					begin
						bit_cnt_reg <= 4'h0;
						wr_en_reg <= !read_reg;
						wr_addr_reg <= addr_reg;
						wr_data_reg <= data_full;
						addr_reg <= addr_step;
						load_rd_reg <= read_reg;
						bytes_left_reg <= bytes_left_reg - 2'h1;
						if (!stream_reg && bytes_left_reg == 2'h0)
							phase_reg <= PH_DONE;
					end
				end
				PH_DONE:
					phase_reg <= PH_DONE;
				default:
					phase_reg <= PH_INSTR;
			endcase
		end
	end

	// Local reads take channel A whenever its select bit is set.
	chan_cfg_t rd_local;
	logic [7:0] rd_value;
	assign rd_local = chan_sel_reg[CHAN_A_BIT] ? shadow_a_reg : shadow_b_reg;
	always_comb
	begin
		rd_value = 8'h00;
		case (addr_reg)
			ADDR_SERIAL_PORT_CONFIG:
				rd_value = {1'b0, lsb_first_reg, soft_reset_reg, 2'b11,
					soft_reset_reg, lsb_first_reg, 1'b0};
			ADDR_CHIP_IDENTIFIER:
				rd_value = CHIP_IDENTIFIER;
			ADDR_SPEED_GRADE:
				rd_value = {1'b0, SPEED_GRADE, 4'h0};
			ADDR_CHANNEL_SELECT:
				rd_value = {6'h00, chan_sel_reg};
			ADDR_OPERATING_MODES:
				rd_value = {rd_local.ext_pd_en, 5'h00, rd_local.power_mode};
			ADDR_CLOCK_CONTROL:
				rd_value = {7'h00, shadow_dcs_reg};
			ADDR_CLOCK_DIVIDER:
				rd_value = {5'h00, shadow_div_reg};
			ADDR_SHADOW_COMMIT:
				rd_value = {7'h00, commit_reg};
			default:
				rd_value = 8'h00;
		endcase
	end

	// Read data changes on the falling serial clock so the host samples it
	// on the next rising edge.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !selected)
		begin
			rd_byte_reg <= 8'h00;
			sdio_out <= 1'b0;
			sdio_oe <= 1'b0;
		end
		else
		begin
			if (load_rd_reg)
				rd_byte_reg <= rd_value;
			if (sclk_fall && phase_reg == PH_DATA && read_reg)
			begin
				sdio_oe <= 1'b1;
				sdio_out <= rd_byte_reg[data_pos];
			end
			else if (phase_reg != PH_DATA)
				sdio_oe <= 1'b0;
		end
	end

	// Port configuration and channel selection act at once.
	always_ff @(posedge sys_clk)
	begin
		if (load_defaults)
		begin
			lsb_first_reg <= SERIAL_PORT_CONFIG_RST[SPC_LSB_FIRST_HI];
			soft_reset_reg <= 1'b0;
			chan_sel_reg <= CHANNEL_SELECT_RST;
		end
		else if (wr_en_reg)
		begin
			if (wr_addr_reg == ADDR_SERIAL_PORT_CONFIG)
			begin
				// Either mirror position sets a flag, whatever the shift order.
				lsb_first_reg <= wr_data_reg[SPC_LSB_FIRST_HI]
					|| wr_data_reg[SPC_LSB_FIRST_LO];
				soft_reset_reg <= wr_data_reg[SPC_SOFT_RESET_HI]
					|| wr_data_reg[SPC_SOFT_RESET_LO];
			end
			if (wr_addr_reg == ADDR_CHANNEL_SELECT)
				chan_sel_reg <= wr_data_reg[1:0];
		end
	end

	// Shadow copies of the program registers.
	chan_cfg_t wr_cfg;
	assign wr_cfg = '{ext_pd_en: wr_data_reg[MODES_EXT_PD_BIT],
		power_mode: wr_data_reg[1:0]};

	always_ff @(posedge sys_clk)
	begin
		if (load_defaults)
		begin
			shadow_a_reg <= CHAN_CFG_RST;
			shadow_b_reg <= CHAN_CFG_RST;
			shadow_dcs_reg <= CLOCK_CONTROL_RST[DCS_BIT];
			shadow_div_reg <= CLOCK_DIVIDER_RST;
		end
		else if (wr_en_reg)
		begin
			if (wr_addr_reg == ADDR_OPERATING_MODES)
			begin
				if (chan_sel_reg[CHAN_A_BIT])
					shadow_a_reg <= wr_cfg;
				if (chan_sel_reg[CHAN_B_BIT])
					shadow_b_reg <= wr_cfg;
			end
			if (wr_addr_reg == ADDR_CLOCK_CONTROL)
				shadow_dcs_reg <= wr_data_reg[DCS_BIT];
			if (wr_addr_reg == ADDR_CLOCK_DIVIDER)
				shadow_div_reg <= wr_data_reg[2:0];
		end
	end

	// Commit bit: set by the host, cleared by the bank after one cycle.
	// A host write in the clearing cycle wins, so no commit is lost.
	always_ff @(posedge sys_clk)
	begin
		if (load_defaults)
			commit_reg <= 1'b0;
		else if (wr_en_reg && wr_addr_reg == ADDR_SHADOW_COMMIT)
			commit_reg <= wr_data_reg[COMMIT_BIT];
		else if (commit_reg)
			commit_reg <= 1'b0;
	end

	// Active settings change only on commit or when defaults load, all in the same cycle.
	always_ff @(posedge sys_clk)
	begin
		if (load_defaults)
		begin
			active_a_reg <= CHAN_CFG_RST;
			active_b_reg <= CHAN_CFG_RST;
			active_dcs_reg <= CLOCK_CONTROL_RST[DCS_BIT];
			active_div_reg <= CLOCK_DIVIDER_RST;
		end
		else if (commit_reg)
		begin
			active_a_reg <= shadow_a_reg;
			active_b_reg <= shadow_b_reg;
			active_dcs_reg <= shadow_dcs_reg;
			active_div_reg <= shadow_div_reg;
		end
	end

	// Input clock divider: one enable pulse every ratio plus one cycles.
	logic [2:0] div_cnt_reg;
	always_ff @(posedge sys_clk)
	begin
		if (load_defaults)
		begin
			div_cnt_reg <= 3'h0;
			conv_clk_en <= 1'b0;
		end
		else if (div_cnt_reg >= active_div_reg)
		begin
			div_cnt_reg <= 3'h0;
			conv_clk_en <= 1'b1;
		end
		else
		begin
			div_cnt_reg <= div_cnt_reg + 3'h1;
			conv_clk_en <= 1'b0;
		end
	end

	assign chan_a_cfg = active_a_reg;
	assign chan_b_cfg = active_b_reg;
	assign duty_cycle_stabilizer = active_dcs_reg;
	assign clk_div_ratio = active_div_reg;
	assign lsb_first = lsb_first_reg;

endmodule : adc_cfg_bank

// >>> core/adc_cfg_pkg.sv
/*
 * Constants and types for the dual converter configuration bank:
 * register addresses, field positions, reset values and serial framing.
 * Assumes a single system clock domain; the serial pins are synchronised
 * inside the bank itself.
 */
package adc_cfg_pkg;

	localparam int ADDR_W = 13;

	localparam logic [12:0] ADDR_SERIAL_PORT_CONFIG = 13'h0000;
	localparam logic [12:0] ADDR_CHIP_IDENTIFIER = 13'h0001;
	localparam logic [12:0] ADDR_SPEED_GRADE = 13'h0002;
	localparam logic [12:0] ADDR_CHANNEL_SELECT = 13'h0005;
	localparam logic [12:0] ADDR_OPERATING_MODES = 13'h0008;
	localparam logic [12:0] ADDR_CLOCK_CONTROL = 13'h0009;
	localparam logic [12:0] ADDR_CLOCK_DIVIDER = 13'h000b;
	localparam logic [12:0] ADDR_SHADOW_COMMIT = 13'h00ff;

	localparam logic [7:0] SERIAL_PORT_CONFIG_RST = 8'h18;
	localparam logic [1:0] CHANNEL_SELECT_RST = 2'h3;
	localparam logic [7:0] OPERATING_MODES_RST = 8'h80;
	localparam logic [7:0] CLOCK_CONTROL_RST = 8'h00;
	localparam logic [2:0] CLOCK_DIVIDER_RST = 3'h0;

	// Mirrored bit positions in the serial port configuration register.
	localparam int SPC_LSB_FIRST_HI = 6;
	localparam int SPC_LSB_FIRST_LO = 1;
	localparam int SPC_SOFT_RESET_HI = 5;
	localparam int SPC_SOFT_RESET_LO = 2;

	localparam int MODES_EXT_PD_BIT = 7;
	localparam int CHAN_A_BIT = 0;
	localparam int CHAN_B_BIT = 1;
	localparam int DCS_BIT = 0;
	localparam int COMMIT_BIT = 0;
	localparam int GRADE_LSB = 4;

	// Instruction word layout: read flag, byte count code, address.
	localparam int INSTR_RW_BIT = 15;
	localparam int INSTR_LEN_HI = 14;
	localparam int INSTR_LEN_LO = 13;
	localparam logic [1:0] LEN_STREAM = 2'h3;
	localparam logic [3:0] INSTR_LAST = 4'hf;
	localparam logic [3:0] BYTE_LAST = 4'h7;

	typedef enum logic [1:0] {
		PM_NORMAL = 2'b00,
		PM_POWER_DOWN = 2'b01,
		PM_STANDBY = 2'b10
	} power_mode_t;

	typedef struct packed {
		logic ext_pd_en;
		logic [1:0] power_mode;
	} chan_cfg_t;

	typedef struct packed {
		logic sclk;
		logic csb_n;
		logic sdio;
	} serial_pins_t;

	localparam chan_cfg_t CHAN_CFG_RST = '{
		ext_pd_en: OPERATING_MODES_RST[MODES_EXT_PD_BIT],
		power_mode: OPERATING_MODES_RST[1:0]
	};

endpackage : adc_cfg_pkg

// >>> dv/adc_cfg_bank_assertions.sv
/* Port checker for the configuration bank.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module adc_cfg_bank_assertions
	import adc_cfg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire serial_pins_t pins_in,
	input wire logic sdio_out,
	input wire logic sdio_oe,
	input wire chan_cfg_t chan_a_cfg,
	input wire chan_cfg_t chan_b_cfg,
	input wire logic duty_cycle_stabilizer,
	input wire logic [2:0] clk_div_ratio,
	input wire logic conv_clk_en,
	input wire logic lsb_first
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	wire logic [9:0] cfg = {chan_a_cfg, chan_b_cfg,
		duty_cycle_stabilizer, clk_div_ratio};
	logic [3:0] since_reg;
	logic [2:0] ratio_reg;
	logic chg_reg;
	logic seen_reg;
	// A ratio change may restart the divider phase, so one gap is exempt.
	wire logic chg = chg_reg || clk_div_ratio != ratio_reg;
	wire logic [3:0] gap = {1'b0, clk_div_ratio} + 4'h1;
	always_ff @(posedge sys_clk)
	begin
		ratio_reg <= clk_div_ratio;
		if (!rst_n)
		begin
			since_reg <= 4'h0;
			chg_reg <= 1'b0;
			seen_reg <= 1'b0;
		end
		else
		begin
			since_reg <= conv_clk_en ? 4'h1 : since_reg + 4'h1;
			chg_reg <= clk_div_ratio != ratio_reg || chg_reg && !conv_clk_en;
			seen_reg <= seen_reg || conv_clk_en;
		end
	end
	sequence cfg_moved;
		$changed(cfg);
	endsequence
	sequence cfg_quiet;
		$stable(cfg) [*2];
	endsequence
	a_reset_cfg: assert property (
		$rose(rst_n) |-> cfg == {CHAN_CFG_RST, CHAN_CFG_RST, 4'h0})
		else $error("config not at defaults");
	a_reset_port: assert property (
		$rose(rst_n) |-> !lsb_first && !sdio_oe)
		else $error("port flags not at defaults");
	a_idle_cfg_hold: assert property (
		pins_in.csb_n [*8] |-> $stable(cfg))
		else $error("config moved outside a frame");
	a_idle_order_hold: assert property (
		pins_in.csb_n [*8] |-> $stable(lsb_first))
		else $error("bit order moved outside a frame");
	a_commit_atomic: assert property (
		cfg_moved |=> cfg_quiet)
		else $error("config outputs moved apart");
	a_div_gap: assert property (
		conv_clk_en && seen_reg && !chg |-> since_reg == gap)
		else $error("divider pulse spacing wrong");
	a_div_bound: assert property (
		seen_reg && !chg |-> since_reg <= gap)
		else $error("divider pulse missing");
	a_div_start: assert property (
		$rose(rst_n) |-> ##[0:3] conv_clk_en)
		else $error("divider silent after reset");
endmodule : adc_cfg_bank_assertions

bind adc_cfg_bank adc_cfg_bank_assertions chk_i (.sys_clk, .rst_n,
	.pins_in, .sdio_out, .sdio_oe, .chan_a_cfg, .chan_b_cfg,
	.duty_cycle_stabilizer, .clk_div_ratio, .conv_clk_en, .lsb_first);

// >>> dv/serial_host_model.sv
/* Serial host controller model for the three-wire port.
   Assumes the bench calls xfer and keeps lsb in step with the bank. */
`timescale 1ns/1ps
module serial_host_model
	import adc_cfg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sdio_out,
	input wire logic sdio_oe,
	output serial_pins_t pins
);
	logic sclk = 1'b0;
	logic csb_n = 1'b1;
	logic drv = 1'b0;
	logic dval = 1'b0;
	logic lsb = 1'b0;
	// A released line shows the inverse of its last value, never a hold.
	assign pins = '{sclk: sclk, csb_n: csb_n,
		sdio: sdio_oe ? sdio_out : (drv ? dval : !dval)};
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	// Eight-cycle half periods leave margin over the pin filter.
	task automatic xfer(input logic rd, input logic [12:0] a,
		input logic [7:0] d, output logic [7:0] q);
		logic [23:0] w;
		int j;
		w = {rd, 2'b00, a, d};
		q = 8'h00;
		csb_n = 1'b0;
		for (int i = 0; i < 24; i++)
		begin
			j = lsb ? (i < 16 ? i + 8 : i - 16) : 23 - i;
			drv = !(rd && i > 15);
			dval = drv ? w[j] : dval;
			tick(8);
			sclk = 1'b1;
			if (!drv)
				q[j] = pins.sdio;
			tick(8);
			sclk = 1'b0;
		end
		drv = 1'b0;
		tick(8);
		csb_n = 1'b1;
		tick(8);
	endtask : xfer
endmodule : serial_host_model

// >>> dv/tb_adc_cfg_bank.sv
/* Self-checking bench for the configuration bank.
   Assumes the host model drives the pins and the checker is bound. */
`timescale 1ns/1ps
module tb_adc_cfg_bank;
	import adc_cfg_pkg::*;
	localparam logic [7:0] ID = 8'h3c; // Arbitrary value.
	localparam logic [2:0] GR = 3'h2;
	localparam logic [15:0] DEF = {6'h00, CHAN_CFG_RST, CHAN_CFG_RST, 4'h0};
	logic sys_clk;
	logic rst_n = 1'b0;
	serial_pins_t pins_in;
	logic sdio_out, sdio_oe, duty_cycle_stabilizer, conv_clk_en, lsb_first;
	chan_cfg_t chan_a_cfg, chan_b_cfg;
	logic [2:0] clk_div_ratio;
	logic [7:0] q;
	int fail_count = 0;
	int cmp_count = 0;
	int n;
	logic [12:0] ta [9] = '{13'h0, 13'h1, 13'h2, 13'h5, 13'h8, 13'h9,
		13'hb, 13'hff, 13'h13};
	logic [7:0] te [9] = '{8'h18, ID, {1'b0, GR, 4'h0}, 8'h03, 8'h80,
		8'h00, 8'h00, 8'h00, 8'h00};
	adc_cfg_bank #(.CHIP_IDENTIFIER(ID), .SPEED_GRADE(GR)) dut (.sys_clk, .rst_n,
		.pins_in, .sdio_out, .sdio_oe, .chan_a_cfg, .chan_b_cfg,
		.duty_cycle_stabilizer, .clk_div_ratio, .conv_clk_en, .lsb_first);
	serial_host_model host (.sys_clk, .sdio_out, .sdio_oe, .pins(pins_in));
	function automatic logic [15:0] act();
		return {lsb_first, 5'h00, chan_a_cfg, chan_b_cfg,
			duty_cycle_stabilizer, clk_div_ratio};
	endfunction : act
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, d, q);
	endtask : wr
	task automatic rd(input logic [12:0] a, input logic [7:0] e);
		host.xfer(1'b1, a, 8'h00, q);
		chk(16'(q), 16'(e));
	endtask : rd
	task automatic conclude;
		$display("Checks %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial
	begin
		#700us;
		fail_count++;
		$display("Error %0t: watchdog expired", $time);
		conclude();
	end
	initial
	begin
		host.tick(10);
		rst_n = 1'b1;
		host.tick(5);
		chk(act(), DEF);
		for (int i = 0; i < 9; i++)
			rd(ta[i], te[i]);
		wr(13'h1, 8'ha5);
		wr(13'h2, 8'h70);
		rd(13'h1, ID);
		rd(13'h2, {1'b0, GR, 4'h0});
		wr(13'h8, 8'h01);
		wr(13'h9, 8'h01);
		wr(13'hb, 8'h07);
		chk(act(), DEF);
		rd(13'h8, 8'h01);
		wr(13'hff, 8'h01);
		chk(act(), {6'h00, 3'b001, 3'b001, 1'b1, 3'h7});
		rd(13'hff, 8'h00);
		wr(13'h5, 8'h01);
		wr(13'h8, 8'h02);
		wr(13'h5, 8'h02);
		wr(13'h8, 8'h81);
		wr(13'h9, 8'h00);
		wr(13'hff, 8'h01);
		chk(act(), {6'h00, 3'b010, 3'b101, 1'b0, 3'h7});
		rd(13'h8, 8'h81);
		rd(13'hb, 8'h07);
		wr(13'h5, 8'h01);
		rd(13'h8, 8'h02);
		wr(13'h5, 8'h03);
		rd(13'h8, 8'h02);
		for (int r = 0; r < 8; r++)
		begin
			wr(13'hb, 8'(r));
			wr(13'hff, 8'h01);
			n = 0;
			repeat (8 * (r + 1))
			begin
				host.tick(1);
				n += int'(conv_clk_en);
			end
			chk(16'(n), 16'h8);
			chk(16'(clk_div_ratio), 16'(r));
		end
		wr(13'h0, 8'h5a);
		chk(16'(lsb_first), 16'h1);
		host.lsb = 1'b1;
		rd(13'h0, 8'h5a);
		wr(13'h0, 8'h3c);
		host.lsb = 1'b0;
		chk(act(), DEF);
		rd(13'h5, 8'h03);
		rd(13'h8, 8'h80);
		conclude();
	end
endmodule : tb_adc_cfg_bank
